// ==== rtl/lcd_ctrl_pkg.sv ====
// shared constants and types for the dot-matrix lcd driver control block
package lcd_ctrl_pkg;

	// register word indices; byte address on apb is four times the index
	localparam logic [15:0] IDX_POWER_DUTY = 16'hFF60;
	localparam logic [15:0] IDX_DISPLAY_MODE = 16'hFF61;
	localparam logic [15:0] IDX_CONTRAST = 16'hFF62;

	// display memory word indices: two 8-common pages and the common-16 row
	localparam logic [15:0] IDX_DM_PAGE0 = 16'hF000;
	localparam logic [15:0] IDX_DM_PAGE1 = 16'hF100;
	localparam logic [15:0] IDX_DM_ROW16 = 16'hF200;
	localparam logic [15:0] DM_PAGE_LAST = 16'h0077;
	localparam logic [15:0] DM_ROW16_LAST = 16'h0076;

	localparam int unsigned SEG_N = 60;
	localparam int unsigned COM_N = 17;
	localparam int unsigned BANK_WORDS = 120;
	localparam int unsigned MEM_WORDS = 360;
	localparam int unsigned CNT_W = 20;

	localparam logic [4:0] LAST_COM_DUTY8 = 5'h07;
	localparam logic [4:0] LAST_COM_DUTY16 = 5'h0F;
	localparam logic [4:0] LAST_COM_DUTY17 = 5'h10;

	// one common slot: 32 Hz frame at 1/16 duty; 1/8 duty uses two slots
	localparam int unsigned COM_SLOT_NS = 1953125;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned COM_SLOT_CYC = COM_SLOT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		DUTY_1_17 = 2'b00,
		DUTY_1_16 = 2'b01,
		DUTY_1_8A = 2'b10,
		DUTY_1_8B = 2'b11
	} duty_t;

	// bit order within each struct is d3 down to d0 of the register word
	typedef struct packed {
		logic duty_select_high;
		logic duty_select_low;
		logic reference_select;
		logic bias_power_on;
	} power_duty_t;

	typedef struct packed {
		logic expansion_driver_enable;
		logic force_all_off;
		logic force_all_on;
		logic page_select;
	} display_mode_t;

	localparam power_duty_t POWER_DUTY_RST = power_duty_t'(4'h0);
	localparam display_mode_t DISPLAY_MODE_RST = display_mode_t'(4'h4);

	typedef struct packed {
		logic [16:0] common_outputs;
		logic [59:0] segment_outputs;
		logic frame_polarity;
		logic bias_on;
		logic reference_high;
		logic [3:0] contrast_level;
		logic exp_frame_sync;
		logic exp_line_clock;
	} lcd_drive_t;

endpackage

// ==== rtl/lcd_matrix_driver_control.sv ====
// apb-controlled dot-matrix lcd scan driver with display memory
// What this block does
// - bias power bit enables drive voltages; cleared grounds every drive level; resets 0.
// - reference select bit picks higher reference when 1, lower when 0; resets 0.
// - duty bits: 1x gives 1/8 on 8 commons, 01 1/16, 00 1/17.
// - force-all-on drives every segment on, display memory untouched; resets 0.
// - force-all-off drives every segment off, display memory untouched.
// - with both force bits set, all-on wins.
// - force-all-off comes out of reset set, so display starts blank.
// - at 1/8 duty page select picks second memory half when 1, first when 0.
// - at 1/16 or 1/17 duty page select is plain storage.
// - four-bit contrast code scales drive voltage in 16 steps, light to dark.
// - contrast code is not reset; software writes it before use, 7 or 8 typical.
// - expansion enable bit gates the external expansion driver signals; resets 0.
// - memory bit 1 lights its dot, 0 leaves it dark, mapped by address and bit.
// - display memory sits in its reserved range and is readable and writable.
//
// Implementation choice: the APB interface to the registers.
module lcd_matrix_driver_control #(
	parameter int unsigned SLOT_CYCLES = lcd_ctrl_pkg::COM_SLOT_CYC
) (
	input wire logic pclk, // apb clock, 40 MHz
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data, low nibble used
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped word
	output lcd_ctrl_pkg::lcd_drive_t drive // panel and expansion driver signals
);

	typedef struct packed {
		lcd_ctrl_pkg::power_duty_t pd;
		lcd_ctrl_pkg::display_mode_t dm;
		logic [3:0] contrast;
		logic [lcd_ctrl_pkg::CNT_W-1:0] slot_cnt;
		logic [4:0] com;
		logic polarity;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		lcd_ctrl_pkg::lcd_drive_t drive;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// display memory, deliberately not reset: contents are undefined at power-up
	logic [3:0] mem [lcd_ctrl_pkg::MEM_WORDS];

	// ---------------- apb address decode ----------------
	logic [15:0] idx;
	logic word_ok;
	logic [15:0] off0;
	logic [15:0] off1;
	logic [15:0] off2;
	logic hit_pd;
	logic hit_dm;
	logic hit_lc;
	logic hit_mem;
	logic [8:0] mem_idx;
	logic acc_done;
	logic do_write;

	assign idx = paddr[17:2];
	assign word_ok = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0000);
	assign off0 = idx - lcd_ctrl_pkg::IDX_DM_PAGE0;
	assign off1 = idx - lcd_ctrl_pkg::IDX_DM_PAGE1;
	assign off2 = idx - lcd_ctrl_pkg::IDX_DM_ROW16;
	assign hit_pd = word_ok && (idx == lcd_ctrl_pkg::IDX_POWER_DUTY);
	assign hit_dm = word_ok && (idx == lcd_ctrl_pkg::IDX_DISPLAY_MODE);
	assign hit_lc = word_ok && (idx == lcd_ctrl_pkg::IDX_CONTRAST);

	// holes between the populated ranges answer with an error
	always_comb begin
		hit_mem = 1'b0;
		mem_idx = 9'h000;
		if (word_ok && idx >= lcd_ctrl_pkg::IDX_DM_PAGE0 &&
				off0 <= lcd_ctrl_pkg::DM_PAGE_LAST) begin
			hit_mem = 1'b1;
			mem_idx = off0[8:0];
		end else if (word_ok && idx >= lcd_ctrl_pkg::IDX_DM_PAGE1 &&
				off1 <= lcd_ctrl_pkg::DM_PAGE_LAST) begin
			hit_mem = 1'b1;
			mem_idx = 9'(lcd_ctrl_pkg::BANK_WORDS) + off1[8:0];
		end else if (word_ok && idx >= lcd_ctrl_pkg::IDX_DM_ROW16 &&
				off2 <= lcd_ctrl_pkg::DM_ROW16_LAST && !off2[0]) begin
			hit_mem = 1'b1;
			mem_idx = 9'(2 * lcd_ctrl_pkg::BANK_WORDS) + off2[8:0];
		end
	end

	assign acc_done = psel && penable && st_r.pready;
	assign do_write = acc_done && pwrite && !st_r.pslverr;

	// ---------------- common scan sequencing ----------------
	logic duty8;
	logic duty16;
	logic [4:0] last_com;
	logic [lcd_ctrl_pkg::CNT_W-1:0] slot_end;
	logic slot_last;
	logic frame_wrap;
	logic past_last;
	logic [4:0] com_nxt;

	assign duty8 = st_r.pd.duty_select_high;
	assign duty16 = !st_r.pd.duty_select_high && st_r.pd.duty_select_low;
	assign last_com = duty8 ? lcd_ctrl_pkg::LAST_COM_DUTY8 :
		(duty16 ? lcd_ctrl_pkg::LAST_COM_DUTY16 : lcd_ctrl_pkg::LAST_COM_DUTY17);
	// 1/8 duty keeps the 32 Hz frame rate by doubling each slot
	assign slot_end = duty8 ? lcd_ctrl_pkg::CNT_W'(2 * SLOT_CYCLES - 1) :
		lcd_ctrl_pkg::CNT_W'(SLOT_CYCLES - 1);
	assign slot_last = (st_r.slot_cnt >= slot_end);
	// a duty change mid-frame can leave com past the new last one: wrap at once,
	// so no common outside the new duty stays driven for the rest of its slot
	assign past_last = (st_r.com > last_com);
	assign frame_wrap = past_last || (slot_last && (st_r.com == last_com));
	assign com_nxt = frame_wrap ? 5'h00 : (slot_last ? st_r.com + 5'h01 : st_r.com);

	// ---------------- row fetch for the common about to be driven ----------------
	logic [lcd_ctrl_pkg::SEG_N-1:0] row_bits;
	logic [1:0] bank_sel;
	logic half_sel;
	logic [1:0] bit_sel;

	always_comb begin
		if (com_nxt == lcd_ctrl_pkg::LAST_COM_DUTY17) begin
			bank_sel = 2'h2;
			half_sel = 1'b0;
			bit_sel = 2'h0;
		end else begin
			// at 1/8 duty the page bit picks the half; otherwise com[3] does
			bank_sel = {1'b0, duty8 ? st_r.dm.page_select : com_nxt[3]};
			half_sel = com_nxt[2];
			bit_sel = com_nxt[1:0];
		end
	end

	for (genvar s = 0; s < lcd_ctrl_pkg::SEG_N; s++) begin : g_seg
		logic [8:0] ridx;
		assign ridx = 9'(bank_sel * lcd_ctrl_pkg::BANK_WORDS) + 9'(2 * s) + {8'h00, half_sel};
		assign row_bits[s] = mem[ridx][bit_sel];
	end

	// ---------------- next state ----------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;

		// setup phase: answer is prepared so the access phase completes in one cycle
		if (psel && !penable) begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = !(hit_pd || hit_dm || hit_lc || hit_mem);
			st_nxt.prdata = 32'h0000_0000;
			if (hit_pd) begin
				st_nxt.prdata[3:0] = st_r.pd;
			end else if (hit_dm) begin
				st_nxt.prdata[3:0] = st_r.dm;
			end else if (hit_lc) begin
				st_nxt.prdata[3:0] = st_r.contrast;
			end else if (hit_mem) begin
				st_nxt.prdata[3:0] = mem[mem_idx];
			end
		end

		if (do_write && hit_pd) begin
			st_nxt.pd = lcd_ctrl_pkg::power_duty_t'(pwdata[3:0]);
		end
		if (do_write && hit_dm) begin
			st_nxt.dm = lcd_ctrl_pkg::display_mode_t'(pwdata[3:0]);
		end
		if (do_write && hit_lc) begin
			st_nxt.contrast = pwdata[3:0];
		end

		// scan runs continuously; the frame polarity flips once per frame
		st_nxt.slot_cnt = (slot_last || past_last) ? '0 : st_r.slot_cnt + 1'b1;
		st_nxt.com = com_nxt;
		st_nxt.polarity = frame_wrap ? !st_r.polarity : st_r.polarity;

		st_nxt.drive.common_outputs = 17'h0_0001 << com_nxt;
		if (st_r.dm.force_all_on) begin
			st_nxt.drive.segment_outputs = '1;
		end else if (st_r.dm.force_all_off) begin
			st_nxt.drive.segment_outputs = '0;
		end else begin
			st_nxt.drive.segment_outputs = row_bits;
		end
		// generator off pulls every drive level to ground
		if (!st_r.pd.bias_power_on) begin
			st_nxt.drive.common_outputs = '0;
			st_nxt.drive.segment_outputs = '0;
		end
		st_nxt.drive.frame_polarity = st_nxt.polarity;
		st_nxt.drive.bias_on = st_r.pd.bias_power_on;
		st_nxt.drive.reference_high = st_r.pd.reference_select;
		st_nxt.drive.contrast_level = st_r.contrast;
		st_nxt.drive.exp_frame_sync = st_r.dm.expansion_driver_enable && frame_wrap;
		st_nxt.drive.exp_line_clock = st_r.dm.expansion_driver_enable && slot_last;
	end

	// contrast is left out of the reset branch on purpose: it powers up unknown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.pd <= lcd_ctrl_pkg::POWER_DUTY_RST;
			st_r.dm <= lcd_ctrl_pkg::DISPLAY_MODE_RST;
			st_r.slot_cnt <= '0;
			st_r.com <= 5'h00;
			st_r.polarity <= 1'b0;
			st_r.pready <= 1'b0;
			st_r.pslverr <= 1'b0;
			st_r.prdata <= 32'h0000_0000;
			st_r.drive <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge pclk) begin
		if (do_write && hit_mem) begin
			mem[mem_idx] <= pwdata[3:0];
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign drive = st_r.drive;

endmodule

// ==== bench/lcd_matrix_driver_control_sva.sv ====
// assertion checker for the lcd driver control block
module lcd_matrix_driver_control_sva #(
	parameter int unsigned SLOT_CYCLES = 4
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // direction
	input wire logic [31:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire lcd_ctrl_pkg::lcd_drive_t drive // panel lines
);
	logic [3:0] pd_r, md_r;
	logic wr_ok;
	// shadow copies of the control words, tracked from accepted writes
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) begin
			pd_r <= 4'h0;
			md_r <= 4'h4;
		end else if (wr_ok && paddr[17:2] == 16'hFF60) begin
			pd_r <= pwdata[3:0];
		end else if (wr_ok && paddr[17:2] == 16'hFF61) begin
			md_r <= pwdata[3:0];
		end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("ready late");
	chk_hole_err: assert property (psel && !penable && paddr == 32'h3C1E0 |=> pslverr)
		else $error("hole not refused");
	chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read data");
	chk_power_gnd: assert property (!drive.bias_on && !$past(drive.bias_on)
		|-> drive.common_outputs == '0 && drive.segment_outputs == '0) else $error("drive when off");
	chk_mirror: assert property ($stable(pd_r[1:0])
		|-> {drive.reference_high, drive.bias_on} == pd_r[1:0]) else $error("mirror");
	chk_one_com: assert property (drive.bias_on && $past(drive.bias_on)
		|-> $onehot(drive.common_outputs)) else $error("common not one-hot");
	chk_scan_step: assert property (drive.bias_on && $onehot($past(drive.common_outputs))
		&& $changed(drive.common_outputs) && !drive.common_outputs[0]
		|-> drive.common_outputs == $past(drive.common_outputs) << 1) else $error("scan order");
	chk_duty_eight: assert property (pd_r[3] && $past(pd_r[3])
		|-> drive.common_outputs[16:8] == '0) else $error("common beyond 7");
	chk_all_on: assert property (md_r[1] && $past(md_r[1]) && drive.bias_on
		&& $past(drive.bias_on) |-> &drive.segment_outputs) else $error("all on");
	chk_all_off: assert property (md_r[2:1] == 2'b10 && $past(md_r[2:1]) == 2'b10
		&& drive.bias_on |-> drive.segment_outputs == '0) else $error("all off");
	chk_exp_gate: assert property (!md_r[3] && !$past(md_r[3])
		|-> !drive.exp_frame_sync && !drive.exp_line_clock) else $error("expansion");
	chk_polarity_flip: assert property (drive.bias_on && $past(drive.bias_on)
		&& $changed(drive.frame_polarity) |-> drive.common_outputs[0]) else $error("polarity");
	chk_exp_sync: assert property (drive.exp_frame_sync && drive.bias_on
		|-> drive.common_outputs[0]) else $error("frame sync");
	cover property (pready && pslverr);
	cover property (pd_r[3] && drive.common_outputs[7]);
	cover property (drive.exp_line_clock);
endmodule

// ==== bench/lcd_panel_model.sv ====
// panel stand-in: reports the active common and whether dot 0 on it is lit
module lcd_panel_model (
	input wire logic pclk, // clock
	input wire lcd_ctrl_pkg::lcd_drive_t drive, // panel lines
	output logic [4:0] com_idx, // active common, 1F when none
	output logic dot0 // segment 0 dot lit
);
	always_ff @(posedge pclk) begin
		com_idx <= 5'h1F;
		for (int i = 0; i < 17; i++)
			if (drive.common_outputs[i])
				com_idx <= 5'(i);
		dot0 <= drive.bias_on && drive.segment_outputs[0];
	end
endmodule

// ==== bench/test_lcd_matrix_driver_control.sv ====
// self-checking bench for the lcd driver control block
module test_lcd_matrix_driver_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned SLOT = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic pready, pslverr, dot0, e;
	logic [4:0] com_idx;
	logic [3:0] q;
	lcd_ctrl_pkg::lcd_drive_t drive;
	int n_mismatch = 0, checked = 0, n;
	logic [15:0] t_idx [7] = '{16'hFF60, 16'hFF60, 16'hFF61, 16'hFF62, 16'hFF62, 16'hF078, 16'hF201};
	logic [3:0] t_val [7] = '{4'hA, 4'h5, 4'hB, 4'h7, 4'h8, 4'h5, 4'h3};
	logic [4:0] t_exp [7] = '{5'h0A, 5'h05, 5'h0B, 5'h07, 5'h08, 5'h10, 5'h10};
	always #12.5 pclk = ~pclk;
	lcd_matrix_driver_control #(.SLOT_CYCLES(SLOT)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive));
	lcd_panel_model pm_u (.pclk(pclk), .drive(drive), .com_idx(com_idx), .dot0(dot0));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] idx, input logic [3:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {14'h0, idx, 2'b00};
		pwdata <= {28'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		q = prdata[3:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// leave common c first, so a fresh slot with settled settings is seen
	task automatic wait_com(input logic [4:0] c);
		n = 0;
		// let a setting written just before reach the model's outputs
		repeat (2) @(posedge pclk);
		for (int p = 0; p < 2; p++)
			while (((com_idx === c) ^ p[0]) && n < 400) begin
				@(negedge pclk);
				n++;
			end
		if (n >= 400) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 16'hFF60, 0);
		chk(q, 4'h0);
		apb(0, 16'hFF61, 0);
		chk(q, 4'h4);
		for (int i = 0; i < 7; i++) begin
			apb(1, t_idx[i], t_val[i]);
			chk(e, t_exp[i][4]);
			apb(0, t_idx[i], 4'h0);
			chk({e, q}, t_exp[i]);
		end
		chk(drive.contrast_level, 4'h8);
		apb(1, 16'hF000, 4'h1);
		apb(1, 16'hF100, 4'hE);
		apb(1, 16'hFF61, 4'h0);
		apb(1, 16'hFF60, 4'h9);
		wait_com(0);
		chk(dot0, 1'b1);
		apb(1, 16'hFF61, 4'h1);
		wait_com(0);
		chk(dot0, 1'b0);
		apb(1, 16'hFF61, 4'h7);
		wait_com(0);
		chk(dot0, 1'b1);
		apb(1, 16'hFF61, 4'h4);
		wait_com(0);
		chk(dot0, 1'b0);
		apb(0, 16'hF000, 0);
		chk(q, 4'h1);
		apb(1, 16'hFF60, 4'h1);
		wait_com(16);
		n = 0;
		while (com_idx === 5'h10 && n < 400) begin
			@(negedge pclk);
			n++;
		end
		chk(com_idx, 5'h00);
		apb(1, 16'hFF61, 4'h8);
		repeat (2) @(posedge pclk);
		n = 0;
		repeat (40) begin
			@(negedge pclk);
			n += drive.exp_line_clock;
		end
		chk(n, 10);
		apb(1, 16'hFF60, 4'h0);
		repeat (2) @(negedge pclk);
		chk(drive.common_outputs, 17'h0);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 16'hFF61, 0);
		chk(q, 4'h4);
		wrap_up();
	end
endmodule
bind lcd_matrix_driver_control lcd_matrix_driver_control_sva #(.SLOT_CYCLES(SLOT_CYCLES)) sva_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.drive(drive));
